// ### hw/line_noise_timer_and_event_mask.sv
// Line noise timer with group-A/B event enable registers on the control bus
`timescale 1ns/10ps
`include "noise_timer_consts.svh"
module line_noise_timer_and_event_mask #(
	parameter int TICK_CYCLES = `TICK_CYCLES,
	parameter int LIMIT_W     = `NOISE_LIMIT_W,
	parameter int DIVIDER_W   = `NOISE_DIVIDER_W
) (
	input  wire logic                          clk_i,                    // System clock
	input  wire logic                          resetn_i,                 // Async reset, active low
	input  wire noise_timer_pkg::ctl_req_t     ctl_req_i,                // Control bus request
	output noise_timer_pkg::ctl_rsp_t          ctl_rsp_o,                // Control bus read answer
	input  wire noise_timer_pkg::line_state_t  line_state_i,             // Decoded line state
	input  wire noise_timer_pkg::group_b_bits_t receive_events_group_b_i, // Group-B event bits
	input  wire logic [`CTL_DATA_W-1:0]        receive_events_group_a_i, // Group-A event bits
	output logic                               group_b_summary_flag_o,   // Group-B summary
	output logic                               group_a_summary_flag_o,   // Group-A summary
	output logic                               noise_limit_reached_o,    // Pulse: noise limit hit
	output logic [LIMIT_W-1:0]                 noise_count_o,            // Live noise counter
	output logic [DIVIDER_W-1:0]               noise_divider_count_o     // Live divider counter
);
	import noise_timer_pkg::*;

	localparam int TICK_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

	logic [`CTL_DATA_W-1:0] group_a_enable_ff;
	logic [`CTL_DATA_W-1:0] group_b_enable_ff;
	logic [LIMIT_W-1:0]     noise_limit_start_value_ff;
	logic [DIVIDER_W-1:0]   noise_tick_divider_start_value_ff;

	logic [TICK_W-1:0]      tick_cnt_ff;
	logic                   tick;
	logic                   hold_lines;

	logic                   bus_wr;
	logic                   bus_rd;
	logic                   wr_group_a;
	logic                   wr_group_b;
	logic                   wr_limit;
	logic                   wr_divider;
	logic                   start_rewritten_ff;

	logic                   rsp_valid_ff;
	logic [`CTL_DATA_W-1:0] rsp_data_ff;
	logic [`CTL_DATA_W-1:0] nxt_rsp_data;

	logic                   group_a_summary_ff;
	logic                   group_b_summary_ff;
	logic                   nxt_group_a_summary;
	logic                   nxt_group_b_summary;
	logic                   reached;

	// Raw vectors: enable bit n gates event bit n
	function automatic logic hits(input logic [`CTL_DATA_W-1:0] ev,
	                              input logic [`CTL_DATA_W-1:0] en);
		hits = |(ev & en);
	endfunction

	assign bus_wr = ctl_req_i.sel && ctl_req_i.wr;
	assign bus_rd = ctl_req_i.sel && !ctl_req_i.wr;

	// Unmapped addresses miss every strobe, so such writes are dropped
	assign wr_group_a = bus_wr && (ctl_req_i.addr == `ADDR_GROUP_A_ENABLE);
	assign wr_group_b = bus_wr && (ctl_req_i.addr == `ADDR_GROUP_B_ENABLE);
	assign wr_limit   = bus_wr && (ctl_req_i.addr == `ADDR_NOISE_LIMIT);
	assign wr_divider = bus_wr && (ctl_req_i.addr == `ADDR_NOISE_DIVIDER);

	// Lines on which the timer is parked at its start values;
	// every code of the enum is legal, so no default is needed
	function automatic logic holds_counters(input line_state_t s);
		unique case (s)
			LINE_IDLE,
			LINE_HALT,
			LINE_MASTER,
			LINE_QUIET,
			LINE_SIGNAL_ABSENT: holds_counters = 1'b1;
			LINE_NOISE,
			LINE_ACTIVE,
			LINE_UNKNOWN:       holds_counters = 1'b0;
		endcase
	endfunction

	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

	// Free-running tick divider
	// Phase is never realigned to line changes, which costs up to one tick of accuracy
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tick_cnt_ff <= '0;
		end else if (tick) begin
			tick_cnt_ff <= '0;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + TICK_W'(1);
		end
	end

	assign tick = (tick_cnt_ff == TICK_LAST);

	assign hold_lines = holds_counters(line_state_i);

	// All group-B events masked out of reset
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			group_b_enable_ff <= `RST_GROUP_B_ENABLE;
		end else if (wr_group_b) begin
			group_b_enable_ff <= ctl_req_i.wdata;
		end
	end

	// Feeds the group-A summary gate and the bus readback; group-A events live outside
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			group_a_enable_ff <= `RST_GROUP_A_ENABLE;
		end else if (wr_group_a) begin
			group_a_enable_ff <= ctl_req_i.wdata;
		end
	end

	// Bit 7 is simply not stored, so it reads back as zero
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			noise_limit_start_value_ff <= `RST_NOISE_LIMIT;
		end else if (wr_limit) begin
			noise_limit_start_value_ff <= ctl_req_i.wdata[`NOISE_LIMIT_MSB:`NOISE_LIMIT_LSB];
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			noise_tick_divider_start_value_ff <= `RST_NOISE_DIVIDER;
		end else if (wr_divider) begin
			noise_tick_divider_start_value_ff <= ctl_req_i.wdata;
		end
	end

	// Reload one cycle after the write, once the new start value is stored
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			start_rewritten_ff <= 1'b0;
		end else begin
			start_rewritten_ff <= bus_wr && (ctl_req_i.addr == `ADDR_NOISE_LIMIT ||
			                                 ctl_req_i.addr == `ADDR_NOISE_DIVIDER);
		end
	end

	// Unmapped addresses read as zero
	always_comb begin
		nxt_rsp_data = '0;
		unique case (ctl_req_i.addr)
			`ADDR_GROUP_A_ENABLE: nxt_rsp_data = group_a_enable_ff;
			`ADDR_GROUP_B_ENABLE: nxt_rsp_data = group_b_enable_ff;
			`ADDR_NOISE_LIMIT:    nxt_rsp_data = {1'b0, noise_limit_start_value_ff};
			`ADDR_NOISE_DIVIDER:  nxt_rsp_data = noise_tick_divider_start_value_ff;
			default:              nxt_rsp_data = '0;
		endcase
	end

	// Valid is a one-cycle pulse per read; data holds until the next read
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rsp_valid_ff <= 1'b0;
		end else begin
			rsp_valid_ff <= bus_rd;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rsp_data_ff <= '0;
		end else if (bus_rd) begin
			rsp_data_ff <= nxt_rsp_data;
		end
	end

	assign ctl_rsp_o.valid = rsp_valid_ff;
	assign ctl_rsp_o.rdata = rsp_data_ff;

	// A bus reload beats a tick that lands in the same cycle, so that tick is lost;
	// with the free tick phase the first step after a reload comes one to
	// TICK_CYCLES clocks later, an error below one tick that the limit tolerates
	noise_tick_counter #(
		.LIMIT_W   (LIMIT_W),
		.DIVIDER_W (DIVIDER_W)
	) u_counter (
		.clk_i         (clk_i),
		.resetn_i      (resetn_i),
		.tick_i        (tick),
		.hold_i        (hold_lines),
		.reload_i      (start_rewritten_ff),
		.limit_start_i (noise_limit_start_value_ff),
		.div_start_i   (noise_tick_divider_start_value_ff),
		.count_o       (noise_count_o),
		.div_count_o   (noise_divider_count_o),
		.reached_o     (reached)
	);

	// Pulse only; the sticky event bit sits in the group-A event register
	assign noise_limit_reached_o = reached;

	assign nxt_group_b_summary = hits(receive_events_group_b_i, group_b_enable_ff);
	assign nxt_group_a_summary = hits(receive_events_group_a_i, group_a_enable_ff);

	// Summaries registered so they are glitch free toward the top condition register
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			group_b_summary_ff <= 1'b0;
		end else begin
			group_b_summary_ff <= nxt_group_b_summary;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			group_a_summary_ff <= 1'b0;
		end else begin
			group_a_summary_ff <= nxt_group_a_summary;
		end
	end

	assign group_b_summary_flag_o = group_b_summary_ff;
	assign group_a_summary_flag_o = group_a_summary_ff;
endmodule

// ### hw/noise_tick_counter.sv
// Noise counter and its divider counter, stepped once per tick
`timescale 1ns/10ps
module noise_tick_counter #(
	parameter int LIMIT_W   = 7,
	parameter int DIVIDER_W = 8
) (
	input  wire logic                 clk_i,          // System clock
	input  wire logic                 resetn_i,       // Async reset, active low
	input  wire logic                 tick_i,         // One-cycle step strobe
	input  wire logic                 hold_i,         // Line keeps counters loaded
	input  wire logic                 reload_i,       // Start value rewritten
	input  wire logic [LIMIT_W-1:0]   limit_start_i,  // Noise counter start value
	input  wire logic [DIVIDER_W-1:0] div_start_i,    // Divider start value
	output logic      [LIMIT_W-1:0]   count_o,        // Noise counter
	output logic      [DIVIDER_W-1:0] div_count_o,    // Divider counter
	output logic                      reached_o       // Pulse: both counters reached zero
);
	logic [LIMIT_W-1:0]   count_ff;
	logic [DIVIDER_W-1:0] div_ff;
	logic [LIMIT_W-1:0]   nxt_count;
	logic [DIVIDER_W-1:0] nxt_div;
	logic                 reached_ff;
	logic                 nxt_reached;
	logic                 both_zero;

	assign both_zero = (count_ff == '0) && (div_ff == '0);

	always_comb begin
		nxt_count   = count_ff;
		nxt_div     = div_ff;
		nxt_reached = 1'b0;
		if (reload_i) begin
			nxt_count = limit_start_i;
			nxt_div   = div_start_i;
		end else if (tick_i) begin
			if (hold_i) begin
				nxt_count = limit_start_i;
				nxt_div   = div_start_i;
			end else if (both_zero) begin
				nxt_count = limit_start_i;
				nxt_div   = div_start_i;
			end else if (div_ff == '0) begin
				nxt_div   = div_start_i;
				nxt_count = count_ff - LIMIT_W'(1);
			end else begin
				// Counts on from present values after a line change
				nxt_div = div_ff - DIVIDER_W'(1);
			end
			nxt_reached = !hold_i && !both_zero && (nxt_count == '0) && (nxt_div == '0);
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			count_ff <= '0;
			div_ff   <= '0;
		end else begin
			count_ff <= nxt_count;
			div_ff   <= nxt_div;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			reached_ff <= 1'b0;
		end else begin
			reached_ff <= nxt_reached;
		end
	end

	assign count_o     = count_ff;
	assign div_count_o = div_ff;
	assign reached_o   = reached_ff;
endmodule

// ### hw/noise_timer_consts.svh
// Constants for the line noise timer and group-A/B event mask block
`ifndef NOISE_TIMER_CONSTS_SVH
`define NOISE_TIMER_CONSTS_SVH

`define CTL_ADDR_W             5
`define CTL_DATA_W             8
`define ADDR_GROUP_A_ENABLE    5'h0b
`define ADDR_GROUP_B_ENABLE    5'h0c
`define ADDR_NOISE_LIMIT       5'h0d
`define ADDR_NOISE_DIVIDER     5'h0e
`define RST_GROUP_A_ENABLE     8'h00
`define RST_GROUP_B_ENABLE     8'h00
`define RST_NOISE_LIMIT        7'h00
`define RST_NOISE_DIVIDER      8'h00
`define NOISE_LIMIT_W          7
`define NOISE_DIVIDER_W        8
`define NOISE_LIMIT_LSB        0
`define NOISE_LIMIT_MSB        6
`define NOISE_FLAG_BIT         5
`define ADVISED_NOISE_LIMIT    7'h40
`define ADVISED_NOISE_DIVIDER  8'hf9
`define CLK_PERIOD_NS          10
`define TICK_PERIOD_NS         80
`define TICK_CYCLES            ((`TICK_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### hw/noise_timer_pkg.sv
// Types shared by the line noise timer block
package noise_timer_pkg;
`include "noise_timer_consts.svh"

	typedef enum logic [2:0] {
		LINE_IDLE,
		LINE_HALT,
		LINE_MASTER,
		LINE_QUIET,
		LINE_SIGNAL_ABSENT,
		LINE_NOISE,
		LINE_ACTIVE,
		LINE_UNKNOWN
	} line_state_t;

	typedef struct packed {
		logic                    sel;
		logic                    wr;
		logic [`CTL_ADDR_W-1:0]  addr;
		logic [`CTL_DATA_W-1:0]  wdata;
	} ctl_req_t;

	typedef struct packed {
		logic                    valid;
		logic [`CTL_DATA_W-1:0]  rdata;
	} ctl_rsp_t;

	// Last member is bit 0, so idle_state lines up with enable bit 0
	typedef struct packed {
		logic spare_event;
		logic long_idle;
		logic elastic_buffer_error;
		logic cascade_or_connection_event;
		logic unknown_valid;
		logic active_state;
		logic state_limit;
		logic idle_state;
	} group_b_bits_t;

endpackage

// ### testbench/mgmt_proc_model.sv
// Management processor model driving the control bus
`timescale 1ns/10ps
`include "noise_timer_consts.svh"
module mgmt_proc_model (
	input wire logic	clk_i,	// Clock
	output noise_timer_pkg::ctl_req_t	req_o	// Bus request
);
	import noise_timer_pkg::*;
	initial req_o = '0;
	// One request per falling edge, so back-to-back cycles are possible
	task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d);
		@(negedge clk_i);
		req_o <= '{1'b1, w, a, d};
	endtask
	// Released bus shows inverted leftovers, never stale values
	task automatic idle();
		@(negedge clk_i);
		req_o <= '{1'b0, 1'b0, ~req_o.addr, ~req_o.wdata};
	endtask
	task automatic advise();
		xfer(1'b1, 5'h0d, {1'b0, `ADVISED_NOISE_LIMIT});
		xfer(1'b1, 5'h0e, `ADVISED_NOISE_DIVIDER);
	endtask
endmodule

// ### testbench/noise_timer_sva.sv
// Port assertions for the line noise timer
`timescale 1ns/10ps
module noise_timer_sva #(parameter int LIMIT_W = 7, parameter int DIVIDER_W = 8) (
	input wire logic	clk_i,
	input wire logic	resetn_i,
	input wire noise_timer_pkg::ctl_req_t	ctl_req_i,
	input wire noise_timer_pkg::ctl_rsp_t	ctl_rsp_o,
	input wire noise_timer_pkg::line_state_t	line_state_i,
	input wire noise_timer_pkg::group_b_bits_t	receive_events_group_b_i,
	input wire logic [7:0]	receive_events_group_a_i,
	input wire logic	group_b_summary_flag_o,
	input wire logic	group_a_summary_flag_o,
	input wire logic	noise_limit_reached_o,
	input wire logic [LIMIT_W-1:0]	noise_count_o,
	input wire logic [DIVIDER_W-1:0]	noise_divider_count_o
);
	import noise_timer_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	logic [7:0]	en_a_ff, en_b_ff, div_ff;
	logic [LIMIT_W-1:0]	lim_ff;
	logic	wr, rd, hold;
	assign wr = ctl_req_i.sel && ctl_req_i.wr;
	assign rd = ctl_req_i.sel && !ctl_req_i.wr;
	assign hold = line_state_i <= LINE_SIGNAL_ABSENT;
	// Shadow copies so start values are known without peeking inside
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			en_a_ff <= 8'h00;
			en_b_ff <= 8'h00;
			lim_ff <= '0;
			div_ff <= 8'h00;
		end else if (wr) begin
			if (ctl_req_i.addr == 5'h0b) en_a_ff <= ctl_req_i.wdata;
			if (ctl_req_i.addr == 5'h0c) en_b_ff <= ctl_req_i.wdata;
			if (ctl_req_i.addr == 5'h0d) lim_ff <= ctl_req_i.wdata[LIMIT_W-1:0];
			if (ctl_req_i.addr == 5'h0e) div_ff <= ctl_req_i.wdata;
		end
	end
	sequence hold_run;
		(hold && !wr)[*8];
	endsequence
	sequence start_write;
		wr && (ctl_req_i.addr == 5'h0d || ctl_req_i.addr == 5'h0e);
	endsequence
	a_sum_b_tracks: assert property (group_b_summary_flag_o ==
		|($past(receive_events_group_b_i) & $past(en_b_ff))) else $error("summary b wrong");
	a_sum_a_tracks: assert property (group_a_summary_flag_o ==
		|($past(receive_events_group_a_i) & $past(en_a_ff))) else $error("summary a wrong");
	a_read_answer: assert property (ctl_rsp_o.valid == $past(rd))
		else $error("read answer wrong");
	a_read_enable_b: assert property (rd && ctl_req_i.addr == 5'h0c |=>
		ctl_rsp_o.rdata == $past(en_b_ff)) else $error("enable b readback wrong");
	a_limit_bit7: assert property (rd && ctl_req_i.addr == 5'h0d |=> !ctl_rsp_o.rdata[7])
		else $error("limit bit 7 set");
	a_hold_loaded: assert property (hold_run |=> noise_count_o == lim_ff &&
		noise_divider_count_o == div_ff) else $error("counters not held");
	a_write_reload: assert property (start_write |-> ##2 noise_count_o == $past(lim_ff) &&
		noise_divider_count_o == $past(div_ff)) else $error("write reload missing");
	a_pulse_at_zero: assert property (noise_limit_reached_o |->
		(noise_count_o == '0 && noise_divider_count_o == '0) ##1 !noise_limit_reached_o)
		else $error("limit pulse wrong");
	a_count_step: assert property ($changed(noise_count_o) && noise_count_o != $past(lim_ff)
		|-> noise_count_o == LIMIT_W'($past(noise_count_o) - 1'b1) &&
		noise_divider_count_o == $past(div_ff)) else $error("count step wrong");
endmodule
bind line_noise_timer_and_event_mask noise_timer_sva #(.LIMIT_W(LIMIT_W), .DIVIDER_W(DIVIDER_W))
	chk (.clk_i(clk_i), .resetn_i(resetn_i), .ctl_req_i(ctl_req_i), .ctl_rsp_o(ctl_rsp_o),
	.line_state_i(line_state_i), .receive_events_group_b_i(receive_events_group_b_i),
	.receive_events_group_a_i(receive_events_group_a_i),
	.group_b_summary_flag_o(group_b_summary_flag_o),
	.group_a_summary_flag_o(group_a_summary_flag_o),
	.noise_limit_reached_o(noise_limit_reached_o), .noise_count_o(noise_count_o),
	.noise_divider_count_o(noise_divider_count_o));

// ### testbench/tb_line_noise_timer_and_event_mask.sv
// Self-checking bench for the line noise timer
`timescale 1ns/10ps
module tb_line_noise_timer_and_event_mask;
	import noise_timer_pkg::*;
	localparam int TC = 2;
	logic	clk_i = 1'b0;
	logic	resetn_i = 1'b0;
	ctl_req_t	req;
	ctl_rsp_t	rsp;
	line_state_t	line = LINE_IDLE;
	logic [7:0]	ev_b = 8'h00, ev_a = 8'h00, div, v;
	logic [6:0]	cnt;
	logic	sum_b, sum_a, hit;
	logic [7:0]	exp_q[$];
	int	err_total = 0, cmp_count = 0, seed = 16, cyc = 0, n, i;
	always #5 clk_i = ~clk_i;
	mgmt_proc_model mp (.clk_i(clk_i), .req_o(req));
	line_noise_timer_and_event_mask #(.TICK_CYCLES(TC)) uut (.clk_i(clk_i),
		.resetn_i(resetn_i), .ctl_req_i(req), .ctl_rsp_o(rsp), .line_state_i(line),
		.receive_events_group_b_i(ev_b), .receive_events_group_a_i(ev_a),
		.group_b_summary_flag_o(sum_b), .group_a_summary_flag_o(sum_a),
		.noise_limit_reached_o(hit), .noise_count_o(cnt), .noise_divider_count_o(div));
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		mp.xfer(1'b0, a, 8'h00);
	endtask
	task automatic wrap_up();
		$display("Compares %0d errors %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Counting lines rotate every cycle to show state changes do not restart the count
	task automatic wait_hit();
		n = 0;
		while (hit !== 1'b1 && n < 2000) begin
			line <= line_state_t'(3'd5 + 3'(n % 3));
			@(negedge clk_i);
			n++;
		end
		if (n >= 2000) err_total++;
		@(negedge clk_i);
	endtask
	always @(negedge clk_i) begin
		cyc++;
		if (cyc > 5000) begin
			err_total++;
			wrap_up();
		end
		if (rsp.valid === 1'b1) chk("rdata", exp_q.pop_front(), rsp.rdata);
	end
	initial begin
		repeat (5) @(negedge clk_i);
		resetn_i = 1'b1;
		rd(5'h0c, 8'h00);
		rd(5'h0d, 8'h00);
		rd(5'h1f, 8'h00);
		mp.xfer(1'b1, 5'h0d, 8'hff);
		rd(5'h0d, 8'h7f);
		v = $random(seed);
		mp.xfer(1'b1, 5'h0e, v);
		rd(5'h0e, v);
		mp.advise();
		rd(5'h0d, 8'h40);
		rd(5'h0e, 8'hf9);
		for (i = 0; i < 8; i++) begin
			v = $random(seed);
			mp.xfer(1'b1, 5'h0c, 8'h01 << i);
			rd(5'h0c, 8'h01 << i);
			mp.idle();
			ev_b <= v | (8'h01 << i);
			repeat (2) @(negedge clk_i);
			chk("summary_b", 8'h01, {7'h00, sum_b});
			ev_b <= v & ~(8'h01 << i);
			repeat (2) @(negedge clk_i);
			chk("summary_b", 8'h00, {7'h00, sum_b});
		end
		mp.xfer(1'b1, 5'h0b, 8'h20);
		mp.idle();
		ev_a <= 8'h20;
		repeat (2) @(negedge clk_i);
		chk("summary_a", 8'h01, {7'h00, sum_a});
		ev_a <= 8'hdf;
		repeat (2) @(negedge clk_i);
		chk("summary_a", 8'h00, {7'h00, sum_a});
		mp.xfer(1'b1, 5'h0d, 8'h02);
		mp.xfer(1'b1, 5'h0e, 8'h03);
		mp.idle();
		repeat (4) @(negedge clk_i);
		chk("count", 8'h02, {1'b0, cnt});
		chk("divider", 8'h03, div);
		wait_hit();
		wait_hit();
		chk("period", 8'((3 + 4 * 2 + 1) * TC), 8'(n + 1));
		line <= LINE_QUIET;
		// Long enough quiet spell for the hold check to see eight write-free cycles
		repeat (2 * TC + 8) @(negedge clk_i);
		chk("count", 8'h02, {1'b0, cnt});
		chk("divider", 8'h03, div);
		resetn_i = 1'b0;
		repeat (2) @(negedge clk_i);
		resetn_i = 1'b1;
		rd(5'h0c, 8'h00);
		mp.idle();
		repeat (3) @(negedge clk_i);
		wrap_up();
	end
endmodule
